// File: shared/gms_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GMS_MAP_SVH
`define GMS_MAP_SVH

`define GMS_ADDR_W          6
`define GMS_OFF_CTRL        6'h00
`define GMS_OFF_ATTEMPTS    6'h04
`define GMS_OFF_START_DLY   6'h08
`define GMS_OFF_CRANK_T     6'h0C
`define GMS_OFF_REST_T      6'h10
`define GMS_OFF_SAFETY_T    6'h14
`define GMS_OFF_RETURN_T    6'h18
`define GMS_OFF_STATUS      6'h1C

`define GMS_CTRL_MBC        0
`define GMS_CTRL_SPD_LO     1
`define GMS_CTRL_SPD_HI     2
`define GMS_CTRL_OIL        3
`define GMS_CTRL_CAN        4
`define GMS_CTRL_TELE_RUN   5
`define GMS_CTRL_TELE_LOAD  6
`define GMS_CTRL_W          7

`define GMS_RST_CTRL        7'h00
`define GMS_RST_ATTEMPTS    4'h3
`define GMS_RST_START_DLY   16'h0032
`define GMS_RST_CRANK_T     16'h0064
`define GMS_RST_REST_T      16'h0064
`define GMS_RST_SAFETY_T    16'h0064
`define GMS_RST_RETURN_T    16'h012C

`define GMS_CLK_KHZ         20000
`define GMS_TICK_MS         100
`define GMS_TICK_CYCLES     (`GMS_TICK_MS * `GMS_CLK_KHZ)

`endif

// File: shared/gms_pkg.sv
// Types shared by the genset mode and start sequencer
`default_nettype none
package gms_pkg;

    typedef enum logic [3:0] {
        MODE_STOP   = 4'h1,
        MODE_MANUAL = 4'h2,
        MODE_TEST   = 4'h4,
        MODE_AUTO   = 4'h8
    } gms_mode_e;

    typedef enum logic [7:0] {
        SEQ_IDLE      = 8'h01,
        SEQ_START_DLY = 8'h02,
        SEQ_CRANK     = 8'h04,
        SEQ_REST      = 8'h08,
        SEQ_SAFETY    = 8'h10,
        SEQ_RUNNING   = 8'h20,
        SEQ_RETURN    = 8'h40,
        SEQ_FAILED    = 8'h80
    } gms_seq_e;

    typedef struct packed {
        logic btn_stop;
        logic btn_manual;
        logic btn_test;
        logic btn_auto;
        logic btn_start;
        logic btn_xfer_gen;
        logic btn_open_gen;
        logic mains_fail;
        logic remote_start;
        logic remote_start_load;
        logic aux_xfer_gen;
        logic aux_xfer_mains;
        logic aux_mains_fail;
        logic load_inhibit;
        logic panel_lock;
        logic sched_run;
        logic sched_on_load;
        logic balance;
        logic gen_available;
        logic alt_fired;
        logic mpu_fired;
        logic ecu_fired;
        logic oil_rising;
    } gms_pins_s;

    typedef struct packed {
        logic       fuel;
        logic       starter;
        logic       can_start;
        logic       load_close;
        logic       delayed_load;
        logic       safety_mask;
        logic       fail_to_start;
        logic [3:0] mode_led;
    } gms_outs_s;

endpackage : gms_pkg
`default_nettype wire

// File: verilog/gms_sequencer.sv
// Genset mode, load transfer and crank/start sequencer with Avalon-MM regs
`include "gms_map.svh"
`default_nettype none

module gms_sequencer #(
    parameter int TICK_CYCLES = `GMS_TICK_CYCLES
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic [`GMS_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic [31:0]                 avs_readdata,
    output logic                        avs_waitrequest,
    input  wire gms_pkg::gms_pins_s     pins,
    output gms_pkg::gms_outs_s          outs
);
    import gms_pkg::*;

    // Merge written bytes into a stored word
    function automatic logic [31:0] be_merge(
        input logic [31:0] old_val,
        input logic [31:0] wdata,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // Duration belonging to a timed state
    function automatic logic [15:0] dur_sel(
        input gms_seq_e    st,
        input logic [15:0] d_start, d_crank, d_rest, d_safe, d_ret
    );
        case (st)
            SEQ_START_DLY: dur_sel = d_start;
            SEQ_CRANK:     dur_sel = d_crank;
            SEQ_REST:      dur_sel = d_rest;
            SEQ_SAFETY:    dur_sel = d_safe;
            SEQ_RETURN:    dur_sel = d_ret;
            default:       dur_sel = 16'hFFFF;
        endcase
    endfunction : dur_sel

    // Pin synchronisers; edge detect compares the second stage with the third
    gms_pins_s   in_s1_reg;
    gms_pins_s   in_s2_reg;
    gms_pins_s   in_s3_reg;
    gms_pins_s   p;
    logic [`GMS_CTRL_W-1:0] ctrl_reg;
    logic [3:0]  attempts_cfg_reg;
    logic [15:0] start_dly_reg;
    logic [15:0] crank_t_reg;
    logic [15:0] rest_t_reg;
    logic [15:0] safety_t_reg;
    logic [15:0] return_t_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;
    gms_mode_e   mode_reg;
    gms_mode_e   mode_next;
    gms_seq_e    seq_reg;
    gms_seq_e    seq_next;
    logic [31:0] presc_reg;
    logic [15:0] timer_reg;
    logic [3:0]  att_reg;
    logic        manual_req_reg;
    logic        load_reg;
    logic        load_next;
    logic        dload_reg;
    logic        fail_reg;
    always_ff @(posedge mclk) begin
        if (rst) begin
            in_s1_reg <= '0;
            in_s2_reg <= '0;
            in_s3_reg <= '0;
        end else begin
            in_s1_reg <= pins;
            in_s2_reg <= in_s1_reg;
            in_s3_reg <= in_s2_reg;
        end
    end
    assign p = in_s2_reg;

    // Button presses as one-cycle pulses
    wire stop_p   = p.btn_stop     & ~in_s3_reg.btn_stop;
    wire man_p    = p.btn_manual   & ~in_s3_reg.btn_manual;
    wire test_p   = p.btn_test     & ~in_s3_reg.btn_test;
    wire auto_p   = p.btn_auto     & ~in_s3_reg.btn_auto;
    wire start_p  = p.btn_start    & ~in_s3_reg.btn_start;
    wire xgen_p   = p.btn_xfer_gen & ~in_s3_reg.btn_xfer_gen;
    wire open_p   = p.btn_open_gen & ~in_s3_reg.btn_open_gen;

    // Mode buttons are dead while the panel is locked
    wire lock     = p.panel_lock;
    wire stop_sel = stop_p & ~lock;
    wire auto_sel = auto_p & ~lock & ~stop_p;

    // Register bus: one wait cycle, then the answer
    wire req      = avs_read | avs_write;
    wire wr_take  = avs_write & ack_reg;
    assign avs_waitrequest = req & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    wire mbc      = ctrl_reg[`GMS_CTRL_MBC];
    wire [1:0] spd_src = ctrl_reg[`GMS_CTRL_SPD_HI:`GMS_CTRL_SPD_LO];
    wire oil_en   = ctrl_reg[`GMS_CTRL_OIL];
    wire can_en   = ctrl_reg[`GMS_CTRL_CAN];
    wire tele_run = ctrl_reg[`GMS_CTRL_TELE_RUN];
    wire tele_ld  = ctrl_reg[`GMS_CTRL_TELE_LOAD];

    wire [31:0] status_w = {11'h000, fail_reg, outs.safety_mask, load_reg,
                            outs.starter, outs.fuel, att_reg,
                            8'(seq_reg), 4'(mode_reg)};

    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            `GMS_OFF_CTRL:      rd_mux = {25'h0000000, ctrl_reg};
            `GMS_OFF_ATTEMPTS:  rd_mux = {28'h0000000, attempts_cfg_reg};
            `GMS_OFF_START_DLY: rd_mux = {16'h0000, start_dly_reg};
            `GMS_OFF_CRANK_T:   rd_mux = {16'h0000, crank_t_reg};
            `GMS_OFF_REST_T:    rd_mux = {16'h0000, rest_t_reg};
            `GMS_OFF_SAFETY_T:  rd_mux = {16'h0000, safety_t_reg};
            `GMS_OFF_RETURN_T:  rd_mux = {16'h0000, return_t_reg};
            `GMS_OFF_STATUS:    rd_mux = status_w;
            default:            rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= req & ~ack_reg;
            if (avs_read & ~ack_reg) begin
                rdata_reg <= rd_mux;
            end
        end
    end

    // Addressed word with the written byte lanes merged in
    wire [31:0] wr_word = be_merge(rd_mux, avs_writedata, avs_byteenable);
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_reg         <= `GMS_RST_CTRL;
            attempts_cfg_reg <= `GMS_RST_ATTEMPTS;
            start_dly_reg    <= `GMS_RST_START_DLY;
            crank_t_reg      <= `GMS_RST_CRANK_T;
            rest_t_reg       <= `GMS_RST_REST_T;
            safety_t_reg     <= `GMS_RST_SAFETY_T;
            return_t_reg     <= `GMS_RST_RETURN_T;
        end else if (wr_take) begin
            case (avs_address)
                `GMS_OFF_CTRL:      ctrl_reg <= wr_word[`GMS_CTRL_W-1:0];
                `GMS_OFF_ATTEMPTS:  attempts_cfg_reg <= wr_word[3:0];
                `GMS_OFF_START_DLY: start_dly_reg <= wr_word[15:0];
                `GMS_OFF_CRANK_T:   crank_t_reg <= wr_word[15:0];
                `GMS_OFF_REST_T:    rest_t_reg <= wr_word[15:0];
                `GMS_OFF_SAFETY_T:  safety_t_reg <= wr_word[15:0];
                `GMS_OFF_RETURN_T:  return_t_reg <= wr_word[15:0];
                default: ;
            endcase
        end
    end

    // Start and loading requests
    wire auto_req = p.mains_fail | p.remote_start | p.remote_start_load
                  | p.aux_mains_fail | p.sched_run | tele_run
                  | p.balance;
    wire ld_src   = p.mains_fail | p.remote_start_load
                  | p.aux_xfer_gen | p.aux_mains_fail | p.sched_on_load
                  | p.balance | tele_ld;
    wire ld_full  = manual_req_reg | ld_src;
    wire ld_mbc   = manual_req_reg | p.aux_xfer_gen;
    wire ld_man   = mbc ? ld_mbc : ld_full;

    // Firing: chosen speed source, optionally rising oil pressure
    wire spd_fired = (spd_src == 2'h1) ? p.mpu_fired :
                     (spd_src == 2'h2) ? p.ecu_fired :
                                         p.alt_fired;
    wire fired    = spd_fired | (oil_en & p.oil_rising);

    always_comb begin
        mode_next = mode_reg;
        if (!lock) begin
            if (stop_p) begin
                mode_next = MODE_STOP;
            end else if (auto_p) begin
                mode_next = MODE_AUTO;
            end else if (test_p) begin
                mode_next = MODE_TEST;
            end else if (man_p) begin
                mode_next = MODE_MANUAL;
            end
        end
    end

    // Common tick for all sequence timers
    wire tick     = (presc_reg == 32'(TICK_CYCLES - 1));
    wire [15:0] dur = dur_sel(seq_reg, start_dly_reg, crank_t_reg,
                              rest_t_reg, safety_t_reg, return_t_reg);
    wire expired  = (timer_reg >= dur);
    wire last_att = ((att_reg + 4'h1) >= attempts_cfg_reg);

    always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
            SEQ_IDLE: begin
                if (mode_reg == MODE_AUTO && auto_req) begin
                    seq_next = SEQ_START_DLY;
                end else if ((mode_reg == MODE_MANUAL ||
                              mode_reg == MODE_TEST) && start_p) begin
                    seq_next = SEQ_CRANK;
                end
            end
            SEQ_START_DLY: begin
                if (mode_reg != MODE_AUTO || !auto_req) begin
                    seq_next = SEQ_IDLE;
                end else if (expired) begin
                    seq_next = SEQ_CRANK;
                end
            end
            SEQ_CRANK: begin
                if (fired) begin
                    seq_next = SEQ_SAFETY;
                end else if (expired) begin
                    seq_next = last_att ? SEQ_FAILED : SEQ_REST;
                end
            end
            SEQ_REST: begin
                if (expired) begin
                    seq_next = SEQ_CRANK;
                end
            end
            SEQ_SAFETY: begin
                if (expired) begin
                    seq_next = SEQ_RUNNING;
                end
            end
            SEQ_RUNNING: begin
                // Manual and Test keep running until Stop, or a switch to Auto with no request
                if (mode_reg == MODE_AUTO && !auto_req) begin
                    seq_next = SEQ_RETURN;
                end
            end
            SEQ_RETURN: begin
                if (mode_reg != MODE_AUTO || auto_req) begin
                    seq_next = SEQ_RUNNING;
                end else if (expired) begin
                    seq_next = SEQ_IDLE;
                end
            end
            SEQ_FAILED: seq_next = SEQ_FAILED;
            default:    seq_next = SEQ_IDLE;
        endcase
        if (stop_sel) begin
            seq_next = SEQ_IDLE;
        end
    end

    // Load switch: open sources win over closing in the same cycle
    wire running  = (seq_next == SEQ_RUNNING) || (seq_next == SEQ_RETURN);
    wire ld_req   = (mode_reg == MODE_MANUAL) ? ld_man :
                    (mode_reg == MODE_TEST)   ? 1'b1 :
                    (mode_reg == MODE_AUTO)   ? 1'b1 : 1'b0;
    wire open_src = open_p | p.aux_xfer_mains;
    wire open_man = (mode_reg == MODE_MANUAL) &&
                    (mbc ? open_src : (open_src & ~ld_src));
    wire open_any = stop_sel | p.load_inhibit | ~running
                  | (auto_sel & mbc)
                  | (auto_sel & ~ld_man & (mode_reg == MODE_MANUAL));
    wire close_ld = running & p.gen_available & ld_req;

    assign load_next = (open_any | open_man) ? 1'b0
                     : (load_reg | close_ld);

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_reg       <= MODE_STOP;
            seq_reg        <= SEQ_IDLE;
            presc_reg      <= 32'h00000000;
            timer_reg      <= 16'h0000;
            att_reg        <= 4'h0;
            manual_req_reg <= 1'b0;
            load_reg       <= 1'b0;
            dload_reg      <= 1'b0;
            fail_reg       <= 1'b0;
        end else begin
            mode_reg  <= mode_next;
            seq_reg   <= seq_next;
            presc_reg <= tick ? 32'h00000000 : presc_reg + 32'h00000001;
            if (seq_next != seq_reg) begin
                timer_reg <= 16'h0000;
            end else if (tick && timer_reg != 16'hFFFF) begin
                timer_reg <= timer_reg + 16'h0001;
            end
            if (seq_next == SEQ_IDLE) begin
                att_reg <= 4'h0;
            end else if (seq_reg == SEQ_CRANK && seq_next != SEQ_CRANK
                         && !fired) begin
                att_reg <= att_reg + 4'h1;
            end
            // A new press wins over a clear in the same cycle
            if (xgen_p && mode_reg == MODE_MANUAL) begin
                manual_req_reg <= 1'b1;
            end else if (open_src | stop_sel | (mode_next != mode_reg)) begin
                manual_req_reg <= 1'b0;
            end
            load_reg  <= load_next;
            dload_reg <= load_next & load_reg;
            fail_reg  <= (seq_next == SEQ_FAILED);
        end
    end

    // Outputs follow the registered state
    assign outs.fuel = (seq_reg == SEQ_CRANK) || (seq_reg == SEQ_REST)
                    || (seq_reg == SEQ_SAFETY) || (seq_reg == SEQ_RUNNING)
                    || (seq_reg == SEQ_RETURN);
    assign outs.starter       = (seq_reg == SEQ_CRANK);
    // ECU only sees a start while fuel is on
    assign outs.can_start     = can_en & outs.fuel;
    assign outs.load_close    = load_reg;
    assign outs.delayed_load  = dload_reg;
    assign outs.safety_mask   = (seq_reg == SEQ_SAFETY);
    assign outs.fail_to_start = fail_reg;
    assign outs.mode_led      = 4'(mode_reg);

    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    a_stop_kills_run: assert property (
        stop_sel |=> !outs.fuel && !outs.load_close && !outs.delayed_load)
        else $error("stop did not drop fuel and load");
    a_crank_has_fuel: assert property (
        outs.starter |-> outs.fuel)
        else $error("starter without fuel");
    a_fire_drops_starter: assert property (
        seq_reg == SEQ_CRANK && fired && !stop_sel
        |=> !outs.starter && outs.safety_mask)
        else $error("starter held after firing");
    a_fail_count: assert property (
        $rose(fail_reg) |-> $past(att_reg) + 4'h1 >= attempts_cfg_reg)
        else $error("fail raised before attempts used");
    a_load_needs_avail: assert property (
        $rose(load_reg) |-> $past(p.gen_available))
        else $error("load closed with generator unavailable");
    a_lock_holds_mode: assert property (
        lock |=> mode_reg == $past(mode_reg))
        else $error("mode changed under panel lock");
    a_led_tracks_mode: assert property (
        auto_sel |=> outs.mode_led == 4'h8)
        else $error("mode indicator wrong");
    a_test_no_delay: assert property (
        mode_reg == MODE_TEST && seq_reg == SEQ_IDLE && start_p && !stop_sel
        |=> seq_reg == SEQ_CRANK ##0 outs.starter)
        else $error("test start not immediate");
    a_delay_abort: assert property (
        seq_reg == SEQ_START_DLY && !auto_req |=> seq_reg == SEQ_IDLE)
        else $error("start delay not abandoned");
    a_inhibit_opens: assert property (
        p.load_inhibit |=> !load_reg && !outs.delayed_load)
        else $error("load held under inhibit");
    a_mbc_open: assert property (
        mbc && mode_reg == MODE_MANUAL && open_p |=> !load_reg)
        else $error("breaker control open ignored");

endmodule : gms_sequencer
`default_nettype wire

// File: sim/gms_engine_model.sv
// Behavioural engine plant: fires while cranked, then builds voltage
`default_nettype none
module gms_engine_model #(
    parameter int FIRE_CYC  = 8,
    parameter int AVAIL_CYC = 10
) (
    input  wire logic mclk,
    input  wire logic fuel,
    input  wire logic starter,
    input  wire logic can_start,
    input  wire logic fire_en,
    output logic      alt_fired,
    output logic      ecu_fired,
    output logic      gen_available
);
    timeunit 1ns;
    timeprecision 1ps;
    int crank_cnt = 0;
    int run_cnt   = 0;
    // No fuel means no speed: ecu_fired falls with fuel, alt_fired one cycle later
    always_ff @(posedge mclk) begin
        crank_cnt <= (starter && fire_en) ? crank_cnt + 1 : 0;
        run_cnt   <= (fuel && alt_fired) ? run_cnt + 1 : 0;
        alt_fired <= fuel && (alt_fired || crank_cnt >= FIRE_CYC);
    end
    assign ecu_fired     = alt_fired && can_start;
    assign gen_available = alt_fired && run_cnt >= AVAIL_CYC;
endmodule : gms_engine_model
`default_nettype wire

// File: sim/genset_mode_start_sequencer_tb.sv
// Self-checking bench for the genset mode and start sequencer
`include "gms_map.svh"
`default_nettype none
module genset_mode_start_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gms_pkg::*;
    localparam int B_STOP = 22, B_MAN = 21, B_TEST = 20, B_AUTO = 19;
    localparam int B_START = 18, O_FUEL = 10, O_STR = 9, O_LOAD = 7;
    localparam int O_FAIL = 4, B_XGEN = 17, B_OPEN = 16;
    logic                   mclk = 1'b0;
    logic                   rst  = 1'b1;
    logic [`GMS_ADDR_W-1:0] adr  = '0;
    logic                   rd   = 1'b0;
    logic                   wr   = 1'b0;
    logic [31:0]            wdat = '0;
    logic [31:0]            rdat;
    logic [31:0]            rq;
    logic                   wreq;
    logic                   fire_en = 1'b1;
    logic                   alt_f;
    logic                   ecu_f;
    logic                   gen_av;
    logic                   str_q = 1'b0;
    gms_pins_s              drv = '0;
    gms_pins_s              pins;
    gms_outs_s              outs;
    int                     err_total = 0;
    int                     check_count = 0;
    int                     cyc = 0;
    int                     cranks = 0;

    gms_sequencer #(.TICK_CYCLES(4)) i_dut (
        .mclk(mclk), .rst(rst), .avs_address(adr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hF),
        .avs_readdata(rdat), .avs_waitrequest(wreq), .pins(pins),
        .outs(outs));
    gms_engine_model i_eng (
        .mclk(mclk), .fuel(outs.fuel), .starter(outs.starter),
        .can_start(outs.can_start), .fire_en(fire_en), .alt_fired(alt_f),
        .ecu_fired(ecu_f), .gen_available(gen_av));

    always_comb begin
        pins = drv;
        pins.alt_fired = alt_f;
        pins.ecu_fired = ecu_f;
        pins.gen_available = gen_av;
    end
    initial forever #25 mclk = ~mclk;
    // Whole run needs a few hundred cycles; the ceiling catches hangs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        str_q <= outs.starter;
        if (outs.starter && !str_q)
            cranks <= cranks + 1;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge mclk);
        while (wreq !== 1'b0)
            @(posedge mclk);
        rq = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic wait_out(input int b, input logic v);
        for (int n = 0; n < 3000 && outs[b] !== v; n++)
            @(posedge mclk);
        chk(outs[b], v);
    endtask : wait_out
    task automatic press(input int b);
        drv[b] <= 1'b1;
        repeat (4) @(posedge mclk);
        drv[b] <= 1'b0;
        repeat (4) @(posedge mclk);
    endtask : press

    task automatic t_regs;
        bus(0, `GMS_OFF_ATTEMPTS, 0);
        chk(rq, 32'h3);
        bus(0, `GMS_OFF_START_DLY, 0);
        chk(rq, 32'h32);
        bus(0, 6'h20, 0);
        chk(rq, 32'h0);
        chk(outs.mode_led, 4'h1);
        bus(1, `GMS_OFF_START_DLY, 32'h5);
        bus(1, `GMS_OFF_CRANK_T, 32'h8);
        bus(1, `GMS_OFF_REST_T, 32'h2);
        bus(1, `GMS_OFF_SAFETY_T, 32'h3);
        bus(0, `GMS_OFF_CRANK_T, 0);
        chk(rq, 32'h8);
        $display("test regs done");
    endtask : t_regs
    task automatic t_test;
        press(B_TEST);
        chk(outs.mode_led, 4'h4);
        chk(outs.fuel, 1'b0);
        press(B_START);
        chk(outs.fuel, 1'b1);
        chk(outs.starter, 1'b1);
        wait_out(O_STR, 1'b0);
        chk(outs.safety_mask, 1'b1);
        chk(outs.load_close, 1'b0);
        wait_out(O_LOAD, 1'b1);
        repeat (100) @(posedge mclk);
        chk(outs.delayed_load, 1'b1);
        chk(outs.safety_mask, 1'b0);
        press(B_STOP);
        chk(outs.fuel, 1'b0);
        chk(outs.delayed_load, 1'b0);
        $display("test test-mode done");
    endtask : t_test
    task automatic t_fail;
        int c0;
        fire_en <= 1'b0;
        bus(1, `GMS_OFF_ATTEMPTS, 32'h2);
        bus(1, `GMS_OFF_CTRL, 32'h10);
        drv.panel_lock <= 1'b1;
        repeat (3) @(posedge mclk);
        press(B_MAN);
        chk(outs.mode_led, 4'h1);
        drv.panel_lock <= 1'b0;
        repeat (3) @(posedge mclk);
        press(B_MAN);
        chk(outs.mode_led, 4'h2);
        c0 = cranks;
        press(B_START);
        chk(outs.can_start, 1'b1);
        wait_out(O_FAIL, 1'b1);
        chk(cranks - c0, 2);
        chk(outs.fuel, 1'b0);
        press(B_STOP);
        fire_en <= 1'b1;
        $display("test fail-to-start done");
    endtask : t_fail
    task automatic t_manual;
        bus(1, `GMS_OFF_CTRL, 32'h14);
        press(B_MAN);
        press(B_START);
        wait_out(O_STR, 1'b0);
        chk(outs.safety_mask, 1'b1);
        repeat (40) @(posedge mclk);
        chk(outs.load_close, 1'b0);
        press(B_XGEN);
        chk(outs.load_close, 1'b1);
        press(B_OPEN);
        chk(outs.load_close, 1'b0);
        drv.aux_xfer_gen <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(outs.load_close, 1'b1);
        press(B_OPEN);
        chk(outs.load_close, 1'b1);
        drv.load_inhibit <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(outs.load_close, 1'b0);
        drv.load_inhibit <= 1'b0;
        drv.aux_xfer_gen <= 1'b0;
        bus(1, `GMS_OFF_CTRL, 32'h15);
        drv.mains_fail <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(outs.load_close, 1'b0);
        press(B_XGEN);
        chk(outs.load_close, 1'b1);
        press(B_OPEN);
        chk(outs.load_close, 1'b0);
        drv.mains_fail <= 1'b0;
        press(B_STOP);
        bus(1, `GMS_OFF_CTRL, 32'h10);
        $display("test manual done");
    endtask : t_manual
    task automatic t_auto;
        press(B_AUTO);
        chk(outs.mode_led, 4'h8);
        drv.remote_start <= 1'b1;
        repeat (4) @(posedge mclk);
        drv.remote_start <= 1'b0;
        repeat (40) @(posedge mclk);
        chk(outs.fuel, 1'b0);
        drv.remote_start <= 1'b1;
        repeat (12) @(posedge mclk);
        chk(outs.fuel, 1'b0);
        wait_out(O_FUEL, 1'b1);
        $display("test auto done");
    endtask : t_auto

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        t_regs();
        t_test();
        t_fail();
        t_manual();
        t_auto();
        finish_test();
    end
endmodule : genset_mode_start_sequencer_tb
`default_nettype wire
